// *** src/lbc_pkg.sv ***
// shared constants and types for the led blink controller
package lbc_pkg;

    localparam int DATA_W = 32;
    localparam int ON_W   = 5;
    localparam int OFF_W  = 7;
    localparam int CNT_W  = 16;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [27:0] IDX_ON_TIME  = 28'hB000240;
    localparam logic [27:0] IDX_OFF_TIME = 28'hB000242;
    localparam logic [27:0] IDX_CONTROL  = 28'hB000248;
    localparam logic [27:0] IDX_COUNT    = 28'hB00024A;
    localparam logic [27:0] IDX_IRQ_STAT = 28'hB00024C;

    localparam logic [31:0] ADDR_ON_TIME  = {2'h0, IDX_ON_TIME, 2'h0};
    localparam logic [31:0] ADDR_OFF_TIME = {2'h0, IDX_OFF_TIME, 2'h0};
    localparam logic [31:0] ADDR_CONTROL  = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [31:0] ADDR_COUNT    = {2'h0, IDX_COUNT, 2'h0};
    localparam logic [31:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};

    // reset values: 1 s on, 2 s off, 1200 pairs
    localparam logic [ON_W-1:0]  ON_TIME_RST   = 5'h10;
    localparam logic [OFF_W-1:0] OFF_TIME_RST  = 7'h20;
    localparam logic [CNT_W-1:0] COUNT_RST     = 16'h04B0;
    localparam logic             STOP_EN_RST   = 1'h1;
    localparam logic             BLINK_EN_RST  = 1'h0;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int IRQ_BIT       = 0;
    localparam int HTRANS_ACT    = 1;

    localparam logic [OFF_W-1:0] PHASE_LAST = 7'h01;
    localparam logic [CNT_W-1:0] PAIR_LAST  = 16'h0001;

    // 0.0625 s timebase step
    localparam int CLK_PERIOD_NS   = 20;
    localparam int TICK_PERIOD_NS  = 62500000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_ON   = 3'b010,
        ST_OFF  = 3'b100
    } lbc_state_e;

    typedef struct packed
    {
        logic autoStopEnable;
        logic blinkEnable;
    } lbc_ctrl_s;

    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } lbc_ahb_req_s;

endpackage

// *** src/lbc_tick_gen.sv ***
// timebase divider producing one pulse per blink step
module lbc_tick_gen
    import lbc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic restart,
    output logic      tick
);

    localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] count_r;

    // restart aligns the step grid to the start of a blink run
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            count_r <= '0;
        else if (restart || count_r == LAST)
            count_r <= ZERO;
        else
            count_r <= count_r + CW'(1);
    end

    assign tick = (count_r == LAST) && !restart;

endmodule

// *** src/lbc_blink_controller.sv ***
// led blink controller with ahb-lite register slave
//
// Chosen here: the AHB-Lite interface to the registers.
module lbc_blink_controller
    import lbc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        rtc_domain_reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             lamp_out_n,
    output logic             auto_stop_irq
);

    lbc_ahb_req_s     dataPh_r;
    logic [ON_W-1:0]  onCode_r;
    logic [OFF_W-1:0] offCode_r;
    lbc_ctrl_s        ctrl_r;
    logic [CNT_W-1:0] setCount_r;
    logic [CNT_W-1:0] runCount_r;
    logic             irqStat_r;
    lbc_state_e       blinkState_r;
    logic [OFF_W-1:0] phaseCnt_r;
    logic [31:0]      hrdata_r;
    logic [31:0]      rdata_nxt;

    logic addrPhase;
    logic wrOn;
    logic wrOff;
    logic wrCtrl;
    logic wrCount;
    logic wrStat;
    logic tick;
    logic startBlink;
    logic phaseEnd;
    logic pairDone;
    logic lastPair;
    logic irqSet;

    // single-cycle slave: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    assign addrPhase = hsel && htrans[HTRANS_ACT] && hready;

    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
            dataPh_r <= '0;
        else if (hready)
        begin
            dataPh_r.valid <= addrPhase;
            dataPh_r.write <= hwrite;
            dataPh_r.addr  <= haddr;
        end
    end

    assign wrOn    = dataPh_r.valid && dataPh_r.write && dataPh_r.addr == ADDR_ON_TIME;
    assign wrOff   = dataPh_r.valid && dataPh_r.write && dataPh_r.addr == ADDR_OFF_TIME;
    assign wrCtrl  = dataPh_r.valid && dataPh_r.write && dataPh_r.addr == ADDR_CONTROL;
    assign wrCount = dataPh_r.valid && dataPh_r.write && dataPh_r.addr == ADDR_COUNT;
    assign wrStat  = dataPh_r.valid && dataPh_r.write && dataPh_r.addr == ADDR_IRQ_STAT;

    // read data is sampled in the address phase and held for the data phase
    always_comb
    begin
        rdata_nxt = '0;
        case (haddr)
            ADDR_ON_TIME:  rdata_nxt[ON_W-1:0]  = onCode_r;
            ADDR_OFF_TIME: rdata_nxt[OFF_W-1:0] = offCode_r;
            ADDR_CONTROL:  rdata_nxt[CTRL_STOP_BIT:CTRL_EN_BIT] = ctrl_r;
            ADDR_COUNT:    rdata_nxt[CNT_W-1:0] = setCount_r;
            ADDR_IRQ_STAT: rdata_nxt[IRQ_BIT]   = irqStat_r;
            default:       rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
            hrdata_r <= '0;
        else if (addrPhase && !hwrite)
            hrdata_r <= rdata_nxt;
    end

    // timing fields survive every reset except the rtc domain one
    always_ff @(posedge clk_sys or posedge rtc_domain_reset)
    begin
        if (rtc_domain_reset)
        begin
            onCode_r  <= ON_TIME_RST;
            offCode_r <= OFF_TIME_RST;
        end
        else
        begin
            if (wrOn)
                onCode_r <= hwdata[ON_W-1:0];
            if (wrOff)
                offCode_r <= hwdata[OFF_W-1:0];
        end
    end

    // hardware stop wins over a software write in the same cycle
    always_ff @(posedge clk_sys or posedge rtc_domain_reset)
    begin
        if (rtc_domain_reset)
        begin
            ctrl_r.blinkEnable    <= BLINK_EN_RST;
            ctrl_r.autoStopEnable <= STOP_EN_RST;
        end
        else if (irqSet)
            ctrl_r <= '0;
        else if (wrCtrl)
        begin
            ctrl_r.blinkEnable    <= hwdata[CTRL_EN_BIT];
            ctrl_r.autoStopEnable <= hwdata[CTRL_STOP_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
            setCount_r <= COUNT_RST;
        else if (wrCount)
            setCount_r <= hwdata[CNT_W-1:0];
    end

    lbc_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst || rtc_domain_reset),
        .restart (startBlink),
        .tick    (tick)
    );

    assign startBlink = (blinkState_r == ST_IDLE) && ctrl_r.blinkEnable;
    assign phaseEnd   = tick && (phaseCnt_r == PHASE_LAST);
    assign pairDone   = (blinkState_r == ST_OFF) && phaseEnd && ctrl_r.blinkEnable;
    assign lastPair   = (runCount_r == PAIR_LAST);
    assign irqSet     = pairDone && lastPair && ctrl_r.autoStopEnable;

    // no power-mode gating: the sequencer runs in every low power mode
    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
        begin
            blinkState_r <= ST_IDLE;
            phaseCnt_r   <= '0;
        end
        else
        begin
            case (blinkState_r)
                ST_IDLE:
                begin
                    if (startBlink)
                    begin
                        blinkState_r <= ST_ON;
                        phaseCnt_r   <= OFF_W'(onCode_r);
                    end
                end
                ST_ON:
                begin
                    if (!ctrl_r.blinkEnable)
                        blinkState_r <= ST_IDLE;
                    else if (phaseEnd)
                    begin
                        blinkState_r <= ST_OFF;
                        phaseCnt_r   <= offCode_r;
                    end
                    else if (tick)
                        phaseCnt_r <= phaseCnt_r - PHASE_LAST;
                end
                ST_OFF:
                begin
                    if (!ctrl_r.blinkEnable || irqSet)
                        blinkState_r <= ST_IDLE;
                    else if (phaseEnd)
                    begin
                        blinkState_r <= ST_ON;
                        phaseCnt_r   <= OFF_W'(onCode_r);
                    end
                    else if (tick)
                        phaseCnt_r <= phaseCnt_r - PHASE_LAST;
                end
                default:
                    blinkState_r <= ST_IDLE;
            endcase
        end
    end

    // running count is hidden from software; it reloads at every start
    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
            runCount_r <= COUNT_RST;
        else if (startBlink)
            runCount_r <= setCount_r;
        else if (pairDone && lastPair)
            runCount_r <= setCount_r; // without auto stop the run simply repeats
        else if (pairDone)
            runCount_r <= runCount_r - PAIR_LAST;
    end

    // set wins over a simultaneous write-one clear
    always_ff @(posedge clk_sys or posedge sys_rst or posedge rtc_domain_reset)
    begin
        if (sys_rst || rtc_domain_reset)
            irqStat_r <= 1'b0;
        else if (irqSet)
            irqStat_r <= 1'b1;
        else if (wrStat && hwdata[IRQ_BIT])
            irqStat_r <= 1'b0;
    end

    assign lamp_out_n    = (blinkState_r == ST_ON);
    assign auto_stop_irq = irqStat_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst || rtc_domain_reset);

    a_start_with_on: assert property (
        startBlink |=> lamp_out_n && phaseCnt_r == OFF_W'($past(onCode_r)))
        else $error("blink start did not begin with an on phase");

    a_disable_low: assert property (
        !ctrl_r.blinkEnable && blinkState_r != ST_IDLE |=> !lamp_out_n)
        else $error("lamp not at off level after disable");

    a_on_hold: assert property (
        blinkState_r == ST_ON && !phaseEnd && ctrl_r.blinkEnable |=> lamp_out_n)
        else $error("on phase ended early");

    a_on_to_off: assert property (
        blinkState_r == ST_ON && phaseEnd && ctrl_r.blinkEnable
        |=> !lamp_out_n && blinkState_r == ST_OFF && phaseCnt_r == $past(offCode_r))
        else $error("off phase not loaded from off time");

    a_step_count: assert property (
        blinkState_r == ST_ON && tick && !phaseEnd && ctrl_r.blinkEnable
        |=> phaseCnt_r == $past(phaseCnt_r) - PHASE_LAST)
        else $error("phase counter missed a tick");

    a_pair_dec: assert property (
        pairDone && !lastPair |=> runCount_r == $past(runCount_r) - PAIR_LAST)
        else $error("pair countdown did not step by one");

    a_irq_stop: assert property (
        pairDone && lastPair && ctrl_r.autoStopEnable
        |=> irqStat_r && ctrl_r == '0 ##1 !lamp_out_n)
        else $error("auto stop did not raise status and clear control");

    a_irq_cause: assert property (
        $rose(irqStat_r) |-> $past(pairDone && lastPair && ctrl_r.autoStopEnable))
        else $error("status bit rose without auto stop cause");

    // count expiry without auto stop must leave control, status and run going
    a_no_stop_off: assert property (
        pairDone && lastPair && !ctrl_r.autoStopEnable && !wrCtrl
        |=> ctrl_r.blinkEnable && !$rose(irqStat_r) && runCount_r == $past(setCount_r))
        else $error("count expiry without auto stop changed control or status");

    a_w1c_clear: assert property (
        wrStat && hwdata[IRQ_BIT] && !irqSet |=> !irqStat_r)
        else $error("write one did not clear status");

    a_set_wins: assert property (
        irqSet |=> irqStat_r)
        else $error("status set lost");

    a_count_readback: assert property (
        addrPhase && !hwrite && haddr == ADDR_COUNT
        |=> hrdata == {16'h0000, $past(setCount_r)})
        else $error("count read did not return set value");

    a_resv_zero: assert property (
        hrdata[31:CNT_W] == '0)
        else $error("reserved read bits not zero");

    a_config_write: assert property (
        wrOn |=> onCode_r == $past(hwdata[ON_W-1:0]))
        else $error("on time write lost");

    a_off_write: assert property (
        wrOff |=> offCode_r == $past(hwdata[OFF_W-1:0]))
        else $error("off time write lost");

    a_ctrl_write: assert property (
        wrCtrl && !irqSet
        |=> ctrl_r.blinkEnable == $past(hwdata[CTRL_EN_BIT])
            && ctrl_r.autoStopEnable == $past(hwdata[CTRL_STOP_BIT]))
        else $error("control write lost");

    a_count_write: assert property (
        wrCount |=> setCount_r == $past(hwdata[CNT_W-1:0]))
        else $error("count write lost");

    a_run_load: assert property (
        startBlink |=> runCount_r == $past(setCount_r))
        else $error("pair countdown not loaded at start");

    a_off_hold: assert property (
        blinkState_r == ST_OFF && !phaseEnd && ctrl_r.blinkEnable
        |=> !lamp_out_n && blinkState_r == ST_OFF)
        else $error("off phase ended early");

    a_off_to_on: assert property (
        blinkState_r == ST_OFF && phaseEnd && ctrl_r.blinkEnable && !irqSet
        |=> lamp_out_n && phaseCnt_r == OFF_W'($past(onCode_r)))
        else $error("on phase not loaded from on time");

    c_auto_stop: cover property (irqSet);
    c_off_to_on: cover property (blinkState_r == ST_OFF ##1 blinkState_r == ST_ON);
    c_sw_stop: cover property (blinkState_r != ST_IDLE ##1 !ctrl_r.blinkEnable);
    c_irq_clear: cover property (irqStat_r ##1 !irqStat_r);
    c_no_stop_wrap: cover property (pairDone && lastPair && !ctrl_r.autoStopEnable);

endmodule

// *** verif/lbc_lamp_model.sv ***
// lamp model: measures lit and dark run lengths seen on the lamp pin
module lbc_lamp_model
(
    input  wire logic   clk_sys,
    input  wire logic   lamp_out_n,
    output logic [15:0] litLen,
    output logic [15:0] darkLen,
    output logic [15:0] litCount
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] run;
    logic        prev;

    initial
    begin
        run = 16'h0000;
        prev = 1'b0;
        litLen = 16'h0000;
        darkLen = 16'h0000;
        litCount = 16'h0000;
    end

    // pin high means lit, despite the _n name
    always @(posedge clk_sys)
    begin
        if (lamp_out_n !== prev)
        begin
            if (prev === 1'b1)
                litLen <= run;
            else
                darkLen <= run;
            if (lamp_out_n === 1'b1)
                litCount <= litCount + 16'h0001;
            run <= 16'h0001;
        end
        else
            run <= run + 16'h0001;
        prev <= lamp_out_n;
    end
endmodule

// *** verif/lbc_blink_controller_test.sv ***
// self-checking bench for the led blink controller
module lbc_blink_controller_test
    import lbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TICKS = 4;
    localparam int NROW  = 11;
    // rows: write flag, address, write data, expected read back
    localparam logic        ROW_W [NROW] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
    localparam logic [31:0] ROW_A [NROW] = '{ADDR_ON_TIME, ADDR_OFF_TIME, ADDR_CONTROL,
        ADDR_COUNT, ADDR_IRQ_STAT, ADDR_ON_TIME, ADDR_OFF_TIME, ADDR_COUNT, ADDR_CONTROL,
        ADDR_ON_TIME + 32'h4, ADDR_IRQ_STAT};
    localparam logic [31:0] ROW_D [NROW] = '{0, 0, 0, 0, 0, 32'hFFFFFFE5, 32'hFFFFFF83,
        32'hFFFF0003, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFE};
    localparam logic [31:0] ROW_E [NROW] = '{32'h10, 32'h20, 32'h2, 32'h4B0, 32'h0, 32'h5,
        32'h3, 32'h3, 32'h2, 32'h0, 32'h0};

    logic        clk_sys, sys_rst, rtc_domain_reset, hsel, hwrite, hready;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        hreadyout, hresp, lamp_out_n, auto_stop_irq, rsp;
    logic [15:0] litLen, darkLen, litCount, base;
    int          n_errors, samples_checked, cycles, i;

    assign hready = hreadyout;

    lbc_blink_controller #(.TICK_CYCLES(TICKS)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .rtc_domain_reset(rtc_domain_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lamp_out_n(lamp_out_n),
        .auto_stop_irq(auto_stop_irq));

    lbc_lamp_model lamp (.clk_sys(clk_sys), .lamp_out_n(lamp_out_n), .litLen(litLen),
        .darkLen(darkLen), .litCount(litCount));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; hready is sampled at each phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        @(posedge clk_sys);
        while (hready !== 1'b1)
            @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1)
            @(posedge clk_sys);
        rd = hrdata;
        rsp = hresp;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic row(input int k);
        if (ROW_W[k])
            bus(1'b1, ROW_A[k], ROW_D[k]);
        rdchk(ROW_A[k], ROW_E[k]);
        chk(rsp, 32'h0);
    endtask

    task automatic pulse(input logic rtc);
        @(posedge clk_sys);
        if (rtc)
            rtc_domain_reset <= 1'b1;
        else
            sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rtc_domain_reset <= 1'b0;
        sys_rst <= 1'b0;
    endtask

    // bounded wait for a number of new lit periods
    task automatic waitLit(input logic [15:0] n);
        base = litCount;
        for (int j = 0; j < 300 && litCount !== base + n; j++)
            @(negedge clk_sys);
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            test_done();
        end
    end

    initial
    begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        sys_rst = 1'b1;
        rtc_domain_reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rtc_domain_reset <= 1'b0;
        for (i = 0; i < NROW; i++)
            row(i);
        // times and count set before enabling, never zero
        bus(1'b1, ADDR_ON_TIME, 32'h3);
        bus(1'b1, ADDR_OFF_TIME, 32'h2);
        bus(1'b1, ADDR_COUNT, 32'h2);
        base = litCount;
        bus(1'b1, ADDR_CONTROL, 32'h3);
        for (i = 0; i < 200 && auto_stop_irq !== 1'b1; i++)
            @(negedge clk_sys);
        chk(auto_stop_irq, 1);
        chk(litCount - base, 2);
        chk(litLen, 3 * TICKS);
        chk(darkLen, 2 * TICKS);
        rdchk(ADDR_CONTROL, 32'h0);
        rdchk(ADDR_COUNT, 32'h2);
        repeat (20) @(negedge clk_sys) chk(lamp_out_n, 0);
        rdchk(ADDR_IRQ_STAT, 32'h1);
        bus(1'b1, ADDR_IRQ_STAT, 32'h1);
        rdchk(ADDR_IRQ_STAT, 32'h0);
        chk(auto_stop_irq, 0);
        // auto stop off: the count expires and blinking goes on
        bus(1'b1, ADDR_COUNT, 32'h1);
        bus(1'b1, ADDR_CONTROL, 32'h1);
        waitLit(16'h3);
        chk(litCount - base, 3);
        chk(auto_stop_irq, 0);
        pulse(1'b0);
        rdchk(ADDR_CONTROL, 32'h1);
        rdchk(ADDR_ON_TIME, 32'h3);
        rdchk(ADDR_OFF_TIME, 32'h2);
        rdchk(ADDR_COUNT, 32'h4B0);
        waitLit(16'h2);
        chk(litCount - base, 2);
        chk(litLen, 3 * TICKS);
        chk(darkLen, 2 * TICKS);
        bus(1'b1, ADDR_CONTROL, 32'h0);
        repeat (2) @(negedge clk_sys);
        base = litCount;
        repeat (20) @(negedge clk_sys) chk(lamp_out_n, 0);
        chk(litCount - base, 0);
        pulse(1'b1);
        for (i = 0; i < 5; i++)
            row(i);
        test_done();
    end
endmodule
